// File: logic/mac_if_pkg.sv
// Package: offsets, fields, reset values and carriers of the MAC interface registers
`default_nettype none

package mac_if_pkg;

	// =========================================================
	// Register indices and byte addresses
	localparam logic [11:0] REG_FIFO_ERR_IDX   = 12'h601;
	localparam logic [11:0] REG_DELAY_SEL_IDX  = 12'h602;
	localparam logic [11:0] REG_SERIAL_CTL_IDX = 12'h608;
	localparam logic [15:0] ADDR_FIFO_ERR      = {2'h0, REG_FIFO_ERR_IDX, 2'h0};
	localparam logic [15:0] ADDR_DELAY_SEL     = {2'h0, REG_DELAY_SEL_IDX, 2'h0};
	localparam logic [15:0] ADDR_SERIAL_CTL    = {2'h0, REG_SERIAL_CTL_IDX, 2'h0};

	// =========================================================
	// Field positions
	localparam int BIT_RX_OVF     = 3;
	localparam int BIT_RX_UNF     = 2;
	localparam int BIT_TX_OVF     = 1;
	localparam int BIT_TX_UNF     = 0;
	localparam int BIT_RX_CLK_SEL = 1;
	localparam int BIT_TX_CLK_SEL = 0;
	localparam int BIT_TX_ERR_DIS = 15;
	localparam int BIT_IDX_FORCE  = 14;
	localparam int IDX_MSB        = 13;
	localparam int IDX_LSB        = 10;
	localparam int BIT_IF_EN      = 9;
	localparam int RX_MAG_MSB     = 7;
	localparam int RX_MAG_LSB     = 4;
	localparam int TX_MAG_MSB     = 11;
	localparam int TX_MAG_LSB     = 8;

	// =========================================================
	// Reset values and counts
	localparam logic [3:0]  RST_FIFO_ERR   = 4'h0;
	localparam logic [1:0]  RST_DELAY_SEL  = 2'h0;
	localparam logic [15:0] RST_SERIAL_CTL = 16'h007b;
	localparam logic [1:0]  STRAP_WAIT     = 2'h2;

	// =========================================================
	// Configuration carried to the link clock domain
	typedef struct packed {
		logic       rxClkSel;
		logic       txClkSel;
		logic       txErrSuppress;
		logic       alignForce;
		logic [3:0] alignIdx;
		logic       ifEnable;
		logic [3:0] rxDelayMag;
		logic [3:0] txDelayMag;
	} link_cfg_s;

	localparam link_cfg_s CFG_RST = '0;

endpackage : mac_if_pkg

`default_nettype wire

// File: logic/link_side.sv
// Link clock domain logic: event toggles, configuration capture and link outputs
`timescale 1ns/1ps
`default_nettype none

module link_side
	import mac_if_pkg::*;
(
	input  wire logic      linkClk,        // Link clock
	input  wire logic      reset_n,        // Async reset, active low
	input  wire logic [3:0] evtIn,         // FIFO error pulses
	output logic [3:0]     evtToggle,      // One toggle per error
	input  wire logic      cfgReq,         // Config request toggle
	input  wire link_cfg_s cfgWord,        // Config, stable while pending
	output logic           cfgAck,         // Config acknowledge toggle
	input  wire logic      macTxErr,       // Transmit error from MAC side
	input  wire logic [3:0] alignSearchIdx, // Boundary search result
	output logic           serialTxErr,    // Transmit error passed on
	output logic [3:0]     alignIdx,       // Boundary index in use
	output logic           rxClkDelayEn,   // Receive clock delay on
	output logic           txClkDelayEn,   // Transmit clock delay on
	output logic [3:0]     rxDelayTaps,    // Receive delay magnitude
	output logic [3:0]     txDelayTaps,    // Transmit delay magnitude
	output logic           serialIfEnable  // Serial interface enable
);

	// =========================================================
	// State
	typedef struct packed {
		logic [3:0] evtToggle;
		logic       reqS1;
		logic       reqS2;
		logic       reqSeen;
		link_cfg_s  cfg;
		logic       txErr;
		logic [3:0] alignIdx;
		logic       rxDly;
		logic       txDly;
		logic [3:0] rxTaps;
		logic [3:0] txTaps;
		logic       ifEn;
	} link_state_s;

	link_state_s st_r;
	link_state_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.evtToggle = st_r.evtToggle ^ evtIn;
		st_nxt.reqS1 = cfgReq;
		st_nxt.reqS2 = st_r.reqS1;
		// Word is held by the sender until the acknowledge returns
		if (st_r.reqS2 != st_r.reqSeen) begin
			st_nxt.cfg     = cfgWord;
			st_nxt.reqSeen = st_r.reqS2;
		end
		st_nxt.txErr = macTxErr & ~st_r.cfg.txErrSuppress & st_r.cfg.ifEnable;
		st_nxt.alignIdx = st_r.cfg.alignForce ? st_r.cfg.alignIdx : alignSearchIdx;
		st_nxt.rxDly = st_r.cfg.rxClkSel;
		st_nxt.txDly = st_r.cfg.txClkSel;
		st_nxt.rxTaps = st_r.cfg.rxClkSel ? st_r.cfg.rxDelayMag : 4'h0;
		st_nxt.txTaps = st_r.cfg.txClkSel ? st_r.cfg.txDelayMag : 4'h0;
		st_nxt.ifEn = st_r.cfg.ifEnable;
	end

	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign evtToggle      = st_r.evtToggle;
	assign cfgAck         = st_r.reqSeen;
	assign serialTxErr    = st_r.txErr;
	assign alignIdx       = st_r.alignIdx;
	assign rxClkDelayEn   = st_r.rxDly;
	assign txClkDelayEn   = st_r.txDly;
	assign rxDelayTaps    = st_r.rxTaps;
	assign txDelayTaps    = st_r.txTaps;
	assign serialIfEnable = st_r.ifEn;

	// =========================================================
	// Checks
	AST_TX_ERR_SUPPRESS: assert property (@(posedge linkClk) disable iff (!reset_n)
		st_r.cfg.txErrSuppress |=> !serialTxErr)
		else $error("Transmit error passed while suppressed");

	AST_ALIGN_FORCE: assert property (@(posedge linkClk) disable iff (!reset_n)
		st_r.cfg.alignForce |=> alignIdx == $past(st_r.cfg.alignIdx))
		else $error("Forced boundary index not used");

	AST_DELAY_OFF: assert property (@(posedge linkClk) disable iff (!reset_n)
		!st_r.cfg.rxClkSel |=> (rxDelayTaps == 4'h0) && !rxClkDelayEn)
		else $error("Receive delay active while deselected");

endmodule : link_side

`default_nettype wire

// File: logic/mac_interface_ctrl_status.sv
// MAC interface control and status registers behind an APB slave
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module mac_interface_ctrl_status
	import mac_if_pkg::*;
(
	input  wire logic        clk,             // Management clock
	input  wire logic        reset_n,         // Async reset, active low

	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB enable
	input  wire logic        pwrite,          // APB direction
	input  wire logic [15:0] paddr,           // APB byte address
	input  wire logic [31:0] pwdata,          // APB write data
	input  wire logic [3:0]  pstrb,           // APB byte strobes
	output logic [31:0]      prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error, unmapped

	input  wire logic [15:0] delayMagnitude,  // External delay register
	input  wire logic        ifEnableStrap,   // Strap pin, serial enable

	input  wire logic        linkClk,         // Link clock
	input  wire logic        rxFifoOverflow,  // Pulse on linkClk
	input  wire logic        rxFifoUnderflow, // Pulse on linkClk
	input  wire logic        txFifoOverflow,  // Pulse on linkClk
	input  wire logic        txFifoUnderflow, // Pulse on linkClk
	input  wire logic        macTxErr,        // Transmit error, linkClk
	input  wire logic [3:0]  alignSearchIdx,  // Search result, linkClk
	output logic             serialTxErr,     // Transmit error, linkClk
	output logic [3:0]       alignIdx,        // Boundary index, linkClk
	output logic             rxClkDelayEn,    // Receive delay on, linkClk
	output logic             txClkDelayEn,    // Transmit delay on, linkClk
	output logic [3:0]       rxDelayTaps,     // Receive magnitude, linkClk
	output logic [3:0]       txDelayTaps,     // Transmit magnitude, linkClk
	output logic             serialIfEnable   // Serial enable, linkClk
);

	// =========================================================
	// State
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [3:0]  flags;
		logic [1:0]  delaySel;
		logic [15:0] ctl;
		logic        strapS1;
		logic        strapS2;
		logic [1:0]  strapCnt;
		logic        strapDone;
		logic [3:0]  evtS1;
		logic [3:0]  evtS2;
		logic [3:0]  evtSeen;
		logic        ackS1;
		logic        ackS2;
		logic        cfgReq;
		link_cfg_s   cfgHold;
	} main_state_s;

	main_state_s st_r;
	main_state_s st_nxt;

	// =========================================================
	// Link side
	logic [3:0] evtToggle;
	logic       cfgAck;
	logic [3:0] linkEvt;

	assign linkEvt = {rxFifoOverflow, rxFifoUnderflow, txFifoOverflow, txFifoUnderflow};

	link_side linkSide (
		.linkClk        (linkClk),
		.reset_n        (reset_n),
		.evtIn          (linkEvt),
		.evtToggle      (evtToggle),
		.cfgReq         (st_r.cfgReq),
		.cfgWord        (st_r.cfgHold),
		.cfgAck         (cfgAck),
		.macTxErr       (macTxErr),
		.alignSearchIdx (alignSearchIdx),
		.serialTxErr    (serialTxErr),
		.alignIdx       (alignIdx),
		.rxClkDelayEn   (rxClkDelayEn),
		.txClkDelayEn   (txClkDelayEn),
		.rxDelayTaps    (rxDelayTaps),
		.txDelayTaps    (txDelayTaps),
		.serialIfEnable (serialIfEnable)
	);

	// =========================================================
	// Bus decode
	logic        setup;
	logic        access;
	logic        wrAccess;
	logic        hitFlags;
	logic        hitDelay;
	logic        hitCtl;
	logic        mapped;
	logic [15:0] laneMask;
	logic [3:0]  evt;
	link_cfg_s   cfgNow;

	assign setup    = psel && !penable;
	assign access   = psel && penable && st_r.pready;
	assign wrAccess = access && pwrite;
	assign hitFlags = paddr == ADDR_FIFO_ERR;
	assign hitDelay = paddr == ADDR_DELAY_SEL;
	assign hitCtl   = paddr == ADDR_SERIAL_CTL;
	assign mapped   = hitFlags || hitDelay || hitCtl;
	assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Toggle changes become one-cycle error events here
	assign evt = st_r.evtS2 ^ st_r.evtSeen;

	always_comb begin
		cfgNow               = CFG_RST;
		cfgNow.rxClkSel      = st_r.delaySel[BIT_RX_CLK_SEL];
		cfgNow.txClkSel      = st_r.delaySel[BIT_TX_CLK_SEL];
		cfgNow.txErrSuppress = st_r.ctl[BIT_TX_ERR_DIS];
		cfgNow.alignForce    = st_r.ctl[BIT_IDX_FORCE];
		cfgNow.alignIdx      = st_r.ctl[IDX_MSB:IDX_LSB];
		cfgNow.ifEnable      = st_r.ctl[BIT_IF_EN];
		cfgNow.rxDelayMag    = delayMagnitude[RX_MAG_MSB:RX_MAG_LSB];
		cfgNow.txDelayMag    = delayMagnitude[TX_MAG_MSB:TX_MAG_LSB];
	end

	// =========================================================
	// Next state
	always_comb begin
		st_nxt = st_r;

		// Zero wait state: data and ready prepared in setup
		st_nxt.pready  = setup;
		st_nxt.pslverr = setup && !mapped;
		if (setup && !pwrite) begin
			st_nxt.prdata = 32'h0000_0000;
			if (hitFlags) begin
				st_nxt.prdata[3:0] = st_r.flags;
			end
			if (hitDelay) begin
				st_nxt.prdata[1:0] = st_r.delaySel;
			end
			if (hitCtl) begin
				st_nxt.prdata[15:0] = st_r.ctl;
			end
		end else if (access) begin
			st_nxt.prdata = 32'h0000_0000;
		end

		// Written zero clears, written one keeps, event wins
		if (wrAccess && hitFlags) begin
			st_nxt.flags = st_r.flags & ~(laneMask[3:0] & ~pwdata[3:0]);
		end
		st_nxt.flags = st_nxt.flags | evt;

		if (wrAccess && hitDelay) begin
			st_nxt.delaySel = (st_r.delaySel & ~laneMask[1:0]) | (pwdata[1:0] & laneMask[1:0]);
		end
		if (wrAccess && hitCtl) begin
			st_nxt.ctl = (st_r.ctl & ~laneMask) | (pwdata[15:0] & laneMask);
		end

		// Strap settles through two flops before it is taken
		st_nxt.strapS1 = ifEnableStrap;
		st_nxt.strapS2 = st_r.strapS1;
		if (!st_r.strapDone) begin
			st_nxt.strapCnt = st_r.strapCnt + 2'h1;
			if (st_r.strapCnt == STRAP_WAIT) begin
				st_nxt.strapDone        = 1'b1;
				st_nxt.ctl[BIT_IF_EN] = st_r.strapS2;
			end
		end

		st_nxt.evtS1   = evtToggle;
		st_nxt.evtS2   = st_r.evtS1;
		st_nxt.evtSeen = st_r.evtS2;

		// One word in flight; later changes wait for the acknowledge
		st_nxt.ackS1 = cfgAck;
		st_nxt.ackS2 = st_r.ackS1;
		if ((st_r.ackS2 == st_r.cfgReq) && (cfgNow != st_r.cfgHold)) begin
			st_nxt.cfgHold = cfgNow;
			st_nxt.cfgReq  = ~st_r.cfgReq;
		end
	end

	// =========================================================
	// Registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r          <= '{default: '0};
			st_r.flags    <= RST_FIFO_ERR;
			st_r.delaySel <= RST_DELAY_SEL;
			st_r.ctl      <= RST_SERIAL_CTL;
			st_r.cfgHold  <= CFG_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata  = st_r.prdata;
	assign pready  = st_r.pready;
	assign pslverr = st_r.pslverr;

	// =========================================================
	// Checks
	AST_RX_FLAG_SET: assert property (@(posedge clk) disable iff (!reset_n)
		(evt[BIT_RX_OVF] || evt[BIT_RX_UNF])
		|=> ((st_r.flags[3:2] & $past(evt[3:2])) == $past(evt[3:2])))
		else $error("Receive FIFO flag not set by event");

	AST_TX_FLAG_SET: assert property (@(posedge clk) disable iff (!reset_n)
		(evt[BIT_TX_OVF] || evt[BIT_TX_UNF])
		|=> ((st_r.flags[1:0] & $past(evt[1:0])) == $past(evt[1:0])))
		else $error("Transmit FIFO flag not set by event");

	AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
		(wrAccess && hitFlags && pstrb[0] && !pwdata[BIT_TX_UNF] && !evt[BIT_TX_UNF])
		|=> !st_r.flags[BIT_TX_UNF])
		else $error("Written zero did not clear flag");

	AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!reset_n)
		(access && !pwrite && hitFlags) |-> (prdata[31:4] == 28'h0000000))
		else $error("Reserved flag bits read nonzero");

	AST_ONE_KEEPS: assert property (@(posedge clk) disable iff (!reset_n)
		(wrAccess && hitFlags && pwdata[3:0] == 4'hf)
		|=> ((st_r.flags & $past(st_r.flags)) == $past(st_r.flags)))
		else $error("Written one changed a flag");

	AST_SET_WINS: assert property (@(posedge clk) disable iff (!reset_n)
		(wrAccess && hitFlags && evt[BIT_RX_OVF] && !pwdata[BIT_RX_OVF])
		|=> st_r.flags[BIT_RX_OVF])
		else $error("Event lost against clearing write");

	AST_STRAP_LOAD: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(st_r.strapDone) |-> st_r.ctl[BIT_IF_EN] == $past(st_r.strapS2))
		else $error("Enable not loaded from strap");

	AST_CTL_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
		(wrAccess && hitCtl && pstrb[1] && st_r.strapDone)
		|=> st_r.ctl[BIT_TX_ERR_DIS] == $past(pwdata[BIT_TX_ERR_DIS]))
		else $error("Control bit 15 not written");

	AST_READY: assert property (@(posedge clk) disable iff (!reset_n)
		setup |=> pready ##1 !pready)
		else $error("Ready not given in access cycle");

endmodule : mac_interface_ctrl_status

`default_nettype wire

// File: test/mac_link_model.sv
// Far-side MAC model: FIFO error pulses and transmit status on the link clock
`timescale 1ns/1ps
`default_nettype none

module mac_link_model (
	input  wire logic       linkClk,   // Link clock
	input  wire logic       reset_n,   // Async reset, active low
	input  wire logic       txErrIn,   // Wanted transmit error level
	input  wire logic [3:0] idxIn,     // Wanted search result
	output logic      [3:0] fifoErr,   // Error pulses, one linkClk each
	output logic            macTxErr,  // Transmit error to device
	output logic      [3:0] searchIdx  // Boundary search result
);
	// ==========================================
	// Levels
	// Levels move only on linkClk, as a real MAC would
	always_ff @(posedge linkClk or negedge reset_n) begin
		if (!reset_n) begin
			macTxErr  <= 1'b0;
			searchIdx <= 4'h0;
		end else begin
			macTxErr  <= txErrIn;
			searchIdx <= idxIn;
		end
	end

	// ==========================================
	// Pulses
	// One cycle wide so each error is seen once
	task automatic fire(input logic [3:0] mask);
		@(posedge linkClk);
		fifoErr <= mask;
		@(posedge linkClk);
		fifoErr <= 4'h0;
	endtask : fire

	initial fifoErr = 4'h0;
endmodule : mac_link_model

`default_nettype wire

// File: test/mac_interface_ctrl_status_test.sv
// Self-checking bench for the MAC interface control and status registers
`timescale 1ns/1ps
`default_nettype none

module mac_interface_ctrl_status_test
	import mac_if_pkg::*;
;
	typedef struct packed {
		logic [1:0]  dly;
		logic [15:0] ctl;
		logic [15:0] link;
	} row_s;

	logic        clk            = 1'b0;
	logic        linkClk        = 1'b0;
	logic        reset_n;
	logic        psel           = 1'b0;
	logic        penable        = 1'b0;
	logic        pwrite         = 1'b0;
	logic [15:0] paddr          = 16'h0;
	logic [31:0] pwdata         = 32'h0;
	logic [3:0]  pstrb          = 4'hf;
	logic [15:0] delayMagnitude = 16'h0a50;
	logic        ifEnableStrap  = 1'b1;
	logic        txErrIn        = 1'b1;
	logic [3:0]  idxIn          = 4'h6;
	logic [31:0] prdata;
	logic        pready, pslverr, macTxErr, serialTxErr, rxClkDelayEn, txClkDelayEn, serialIfEnable;
	logic [3:0]  fifoErr, alignSearchIdx, alignIdx, rxDelayTaps, txDelayTaps, flagExp;
	int          errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	// Link outputs: {en rx, en tx, taps rx, taps tx, serial en, tx err, index}
	row_s        rows [3] = '{'{2'h3, 16'h6600, 16'hd6b9}, '{2'h2, 16'h8200, 16'h9426},
	                          '{2'h0, 16'h0000, 16'h0006}};

	always #5 clk = ~clk;
	// Edges fall on falling edges of clk, never on its rising edges
	always #40 linkClk = ~linkClk;

	mac_interface_ctrl_status i_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .delayMagnitude, .ifEnableStrap, .linkClk,
		.rxFifoOverflow(fifoErr[3]), .rxFifoUnderflow(fifoErr[2]), .txFifoOverflow(fifoErr[1]),
		.txFifoUnderflow(fifoErr[0]), .macTxErr, .alignSearchIdx, .serialTxErr, .alignIdx,
		.rxClkDelayEn, .txClkDelayEn, .rxDelayTaps, .txDelayTaps, .serialIfEnable);

	mac_link_model i_mac (.linkClk, .reset_n, .txErrIn, .idxIn, .fifoErr, .macTxErr,
		.searchIdx(alignSearchIdx));

	// ==========================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Wait ends when pready is seen high; the hang guard ends a wait that never does
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask : wr

	task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b0, 32'h0, r, e);
		check(r, exp);
		check({31'h0, e}, {31'h0, expErr});
	endtask : rdchk

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// Hang guard, well above the whole sequence
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end

	// ==========================================
	// Sequence
	initial begin
		// Falling edge at time zero resets the link side before its first edge
		reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		rdchk(ADDR_FIFO_ERR, 32'h0, 1'b0);
		rdchk(ADDR_DELAY_SEL, 32'h0, 1'b0);
		rdchk(ADDR_SERIAL_CTL, 32'h027b, 1'b0);
		$display("Test reset values done");
		// Reserved and upper bits written high must read back zero
		foreach (rows[i]) begin
			wr(ADDR_DELAY_SEL, {16'h0, 14'h3fff, rows[i].dly});
			wr(ADDR_SERIAL_CTL, {16'hffff, rows[i].ctl});
			rdchk(ADDR_DELAY_SEL, {30'h0, rows[i].dly}, 1'b0);
			rdchk(ADDR_SERIAL_CTL, {16'h0, rows[i].ctl}, 1'b0);
			repeat (10) @(posedge linkClk);
			check({16'h0, rxClkDelayEn, txClkDelayEn, rxDelayTaps, txDelayTaps, serialIfEnable,
				serialTxErr, alignIdx}, {16'h0, rows[i].link});
		end
		$display("Test register rows done");
		flagExp = 4'h0;
		for (int i = 0; i < 4; i++) begin
			i_mac.fire(4'h1 << i);
			flagExp[i] = 1'b1;
			repeat (3) @(posedge linkClk);
			rdchk(ADDR_FIFO_ERR, {28'h0, flagExp}, 1'b0);
		end
		wr(ADDR_FIFO_ERR, 32'hffff);
		rdchk(ADDR_FIFO_ERR, 32'hf, 1'b0);
		wr(ADDR_FIFO_ERR, 32'h5);
		rdchk(ADDR_FIFO_ERR, 32'h5, 1'b0);
		$display("Test error flags done");
		wr(16'h1900, 32'h1);
		rdchk(16'h1900, 32'h0, 1'b1);
		$display("Test unmapped done");
		// Reset in mid-run with the strap now low
		@(posedge clk);
		reset_n       <= 1'b0;
		ifEnableStrap <= 1'b0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (5) @(posedge clk);
		rdchk(ADDR_FIFO_ERR, 32'h0, 1'b0);
		rdchk(ADDR_SERIAL_CTL, 32'h007b, 1'b0);
		$display("Test second reset done");
		report_and_stop();
	end
endmodule : mac_interface_ctrl_status_test

`default_nettype wire
